// ==== mbd_pkg.sv ====
/*
 * Shared constants, types and helper functions for the bank-mode sequencer.
 * Assumes a controller on a single-beat memory-mapped bus that has up to four
 * banks and a configuration register block at its own separate base address.
 */
package mbd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths and bank map
    localparam int ADDR_W = 32;
    localparam int DATA_W = 64;
    localparam int STRB_W = 8;
    localparam int BANK_MAX = 4;
    localparam int BANK_NUM = 4;

    localparam logic [BANK_MAX-1:0][ADDR_W-1:0] BANK_BASE = {
        32'h6300_0000, 32'h6200_0000, 32'h6100_0000, 32'h6000_0000
    };
    localparam logic [BANK_MAX-1:0][ADDR_W-1:0] BANK_HIGH = {
        32'h63ff_ffff, 32'h62ff_ffff, 32'h61ff_ffff, 32'h60ff_ffff
    };

    ////////////////////////////////////////////////////////////////////////////
    // Controller register map, seen from outside
    localparam logic [ADDR_W-1:0] REG_BASE = 32'h4000_0000;
    localparam logic [ADDR_W-1:0] CFG_REG_OFFSET = 32'h0000_0010;
    localparam int CFG_REG_SHIFT = 2;
    localparam logic [31:0] CFG_RESET = 32'h0000_0024;
    localparam int CFG_COPY_BIT = 31;
    localparam int CFG_SYNC_BIT = 30;
    localparam logic [31:0] CFG_MODE_BITS = (32'h1 << CFG_COPY_BIT) | (32'h1 << CFG_SYNC_BIT);

    ////////////////////////////////////////////////////////////////////////////
    // Flash read configuration word
    localparam logic [ADDR_W-1:0] FLASH_RCR_ADDR = 32'h0000_284f;
    localparam int RCR_SYNC_READ_BIT = 15;
    localparam logic [ADDR_W-1:0] FLASH_RCR_ASYNC_ADDR =
        FLASH_RCR_ADDR & ~(32'h1 << RCR_SYNC_READ_BIT);
    localparam logic [31:0] FLASH_SWITCH_DATA = 32'h0003_0060;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2,
        SZ_DWORD = 2'h3
    } mbd_size_t;

    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_TO_SYNC = 2'h2,
        OP_TO_ASYNC = 2'h3
    } mbd_op_t;

    typedef struct packed {
        logic valid;
        logic we;
        logic [ADDR_W-1:0] addr;
        mbd_size_t size;
        logic [STRB_W-1:0] strb;
        logic [DATA_W-1:0] wdata;
    } mbd_dev_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [DATA_W-1:0] rdata;
    } mbd_dev_rsp_t;

    typedef struct packed {
        mbd_op_t op;
        logic [1:0] bank;
        logic [ADDR_W-1:0] addr;
        mbd_size_t size;
        logic [DATA_W-1:0] wdata;
    } mbd_cmd_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [DATA_W-1:0] rdata;
    } mbd_rsp_t;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [DATA_W-1:0] size_mask(input mbd_size_t sz);
        unique case (sz)
            SZ_BYTE: size_mask = 64'h0000_0000_0000_00ff;
            SZ_HALF: size_mask = 64'h0000_0000_0000_ffff;
            SZ_WORD: size_mask = 64'h0000_0000_ffff_ffff;
            SZ_DWORD: size_mask = 64'hffff_ffff_ffff_ffff;
        endcase
    endfunction

    function automatic logic [STRB_W-1:0] lane_strb(input mbd_size_t sz, input logic [2:0] off);
        logic [STRB_W-1:0] base;
        unique case (sz)
            SZ_BYTE: base = 8'h01;
            SZ_HALF: base = 8'h03;
            SZ_WORD: base = 8'h0f;
            SZ_DWORD: base = 8'hff;
        endcase
        lane_strb = base << off;
    endfunction

    function automatic logic [DATA_W-1:0] lane_put(input logic [DATA_W-1:0] d,
                                                   input logic [2:0] off);
        lane_put = d << {off, 3'h0};
    endfunction

    function automatic logic [DATA_W-1:0] lane_get(input logic [DATA_W-1:0] d,
                                                   input logic [2:0] off,
                                                   input mbd_size_t sz);
        lane_get = (d >> {off, 3'h0}) & size_mask(sz);
    endfunction

    function automatic logic window_ok(input logic [ADDR_W-1:0] base,
                                       input logic [ADDR_W-1:0] high);
        logic [ADDR_W-1:0] span;
        span = base ^ high;
        window_ok = ((span & (span + 32'h1)) == 32'h0) && ((base & span) == 32'h0)
            && ((high & span) == span);
    endfunction

    function automatic logic [ADDR_W-1:0] cfg_addr(input logic [1:0] bank);
        cfg_addr = REG_BASE + CFG_REG_OFFSET + (32'(bank) << CFG_REG_SHIFT);
    endfunction

endpackage

// ==== mbd_bank_decode.sv ====
/*
 * Bank decoder: finds which configured bank window holds a host address.
 * Assumes the bank map in the package; a bank whose window is not a
 * power-of-two size aligned to itself is never matched.
 */
`timescale 1ns/1ps
module mbd_bank_decode import mbd_pkg::*; (
    input wire logic [ADDR_W-1:0] addr,
    output logic hit,
    output logic [1:0] bank
);

    always_comb begin
        hit = 1'b0;
        bank = 2'h0;
        for (int i = 0; i < BANK_NUM; i++) begin
            // A malformed window is skipped rather than half-decoded
            if (!hit && window_ok(BANK_BASE[i], BANK_HIGH[i]) &&
                addr >= BANK_BASE[i] && addr <= BANK_HIGH[i]) begin
                hit = 1'b1;
                bank = 2'(i);
            end
        end
    end

endmodule

// ==== mbd_mode_host.sv ====
/*
 * Host-side sequencer for an external memory controller: passes user memory
 * accesses to the controller's bus and runs the flash async/sync read switch
 * by writing the per-bank mode configuration and the flash read config word.
 * Assumes a single-beat controller bus that holds each request until ack.
 */
// Notes on behaviour
// - Flash read config word is reached at flash register address 0x284F.
// - Sync burst mode uses only the one prescribed read config pattern.
// - Set bank config bits 31 and 30 before reprogramming the flash.
// - Mode switch is one single-beat word write of 0x0003_0060.
// - No read config value other than the prescribed pattern is ever sent.
// - Going async, clear flash bit 15 first, then config bits 31 and 30.
// - Bank windows are power-of-two sized and aligned to their size.
// - Every memory access lies inside one bank's window.
// - Sync flash with sync SRAM: SRAM wait input left unconnected.
// - Sync flash with async memories: their wait input left unconnected.
`timescale 1ns/1ps
module mbd_mode_host import mbd_pkg::*; (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire mbd_cmd_t cmd,
    output logic cmd_ready,
    output mbd_rsp_t user_rsp,
    output logic [BANK_MAX-1:0] bank_sync,
    output mbd_dev_req_t dev_req,
    input wire mbd_dev_rsp_t dev_rsp
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_MEM = 5'h02,
        ST_CFG_SET = 5'h04,
        ST_RCR_WR = 5'h08,
        ST_CFG_CLR = 5'h10
    } mbd_state_e_t;

    typedef struct packed {
        mbd_state_e_t st;
        mbd_dev_req_t req;
        mbd_rsp_t rsp;
        logic ready;
        mbd_op_t op;
        logic [1:0] bank;
        logic [2:0] lane;
        mbd_size_t size;
        logic err;
        logic [BANK_MAX-1:0][31:0] cfg;
        logic [BANK_MAX-1:0] sync;
    } mbd_host_state_t;

    localparam mbd_host_state_t ST_RESET = '{
        st: ST_IDLE,
        req: '0,
        rsp: '0,
        ready: 1'b1,
        op: OP_READ,
        bank: 2'h0,
        lane: 3'h0,
        size: SZ_BYTE,
        err: 1'b0,
        cfg: {BANK_MAX{CFG_RESET}},
        sync: '0
    };

    mbd_host_state_t s_q;
    mbd_host_state_t s_d;
    logic dec_hit;
    logic [1:0] dec_bank;
    logic acked;

    mbd_bank_decode u_decode (
        .addr(cmd.addr),
        .hit(dec_hit),
        .bank(dec_bank)
    );

    assign acked = s_q.req.valid && dev_rsp.ack;

    ////////////////////////////////////////////////////////////////////////////
    // Bus request builder

    function automatic mbd_dev_req_t make_req(input logic we,
                                              input logic [ADDR_W-1:0] addr,
                                              input mbd_size_t sz,
                                              input logic [DATA_W-1:0] d);
        mbd_dev_req_t r;
        r.valid = 1'b1;
        r.we = we;
        r.addr = addr;
        r.size = sz;
        r.strb = lane_strb(sz, addr[2:0]);
        r.wdata = we ? lane_put(d, addr[2:0]) : '0;
        make_req = r;
    endfunction

    // Flash config write always carries the fixed command word as one beat;
    // the controller, not this block, turns it into two halfword cycles.
    function automatic mbd_dev_req_t rcr_req(input logic [1:0] bank,
                                             input logic [ADDR_W-1:0] flash_read_config_word);
        mbd_dev_req_t r;
        r = make_req(1'b1, BANK_BASE[bank] | flash_read_config_word, SZ_WORD,
                     {32'h0, FLASH_SWITCH_DATA});
        // The register address is odd: placing by its low bits would push the
        // upper halfword off the bus, so the word keeps its aligned lanes
        r.strb = lane_strb(SZ_WORD, {r.addr[2], 2'h0});
        r.wdata = lane_put({32'h0, FLASH_SWITCH_DATA}, {r.addr[2], 2'h0});
        rcr_req = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        s_d = s_q;
        s_d.rsp.valid = 1'b0;
        unique case (s_q.st)
            ST_IDLE: begin
                if (cmd_valid && s_q.ready) begin
                    s_d.op = cmd.op;
                    s_d.lane = cmd.addr[2:0];
                    s_d.size = cmd.size;
                    s_d.err = 1'b0;
                    s_d.ready = 1'b0;
                    unique case (cmd.op)
                        OP_READ, OP_WRITE: begin
                            if (dec_hit) begin
                                s_d.bank = dec_bank;
                                s_d.req = make_req(cmd.op == OP_WRITE, cmd.addr,
                                                   cmd.size, cmd.wdata);
                                s_d.st = ST_MEM;
                            end else begin
                                // Outside every window: never put on the bus
                                s_d.rsp.valid = 1'b1;
                                s_d.rsp.err = 1'b1;
                                s_d.rsp.rdata = '0;
                                s_d.ready = 1'b1;
                            end
                        end
                        OP_TO_SYNC: begin
                            s_d.bank = cmd.bank;
                            if (32'(cmd.bank) >= BANK_NUM) begin
                                s_d.rsp = '{valid: 1'b1, err: 1'b1, rdata: '0};
                                s_d.ready = 1'b1;
                            end else begin
                                s_d.req = make_req(1'b1, cfg_addr(cmd.bank), SZ_WORD,
                                    {32'h0, s_q.cfg[cmd.bank] | CFG_MODE_BITS});
                                s_d.st = ST_CFG_SET;
                            end
                        end
                        OP_TO_ASYNC: begin
                            s_d.bank = cmd.bank;
                            if (32'(cmd.bank) >= BANK_NUM) begin
                                s_d.rsp = '{valid: 1'b1, err: 1'b1, rdata: '0};
                                s_d.ready = 1'b1;
                            end else begin
                                // Flash goes back first while the copy bit still stands
                                s_d.req = rcr_req(cmd.bank, FLASH_RCR_ASYNC_ADDR);
                                s_d.st = ST_RCR_WR;
                            end
                        end
                    endcase
                end
            end
            ST_MEM: begin
                if (acked) begin
                    s_d.req.valid = 1'b0;
                    s_d.rsp.valid = 1'b1;
                    s_d.rsp.err = dev_rsp.err;
                    s_d.rsp.rdata = s_q.req.we ? '0
                        : lane_get(dev_rsp.rdata, s_q.lane, s_q.size);
                    s_d.ready = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            ST_CFG_SET: begin
                if (acked) begin
                    s_d.cfg[s_q.bank] = s_q.cfg[s_q.bank] | CFG_MODE_BITS;
                    s_d.err = s_q.err | dev_rsp.err;
                    s_d.req = rcr_req(s_q.bank, FLASH_RCR_ADDR);
                    s_d.st = ST_RCR_WR;
                end
            end
            ST_RCR_WR: begin
                if (acked) begin
                    s_d.err = s_q.err | dev_rsp.err;
                    if (s_q.op == OP_TO_SYNC) begin
                        s_d.req.valid = 1'b0;
                        s_d.sync[s_q.bank] = 1'b1;
                        s_d.rsp = '{valid: 1'b1, err: s_q.err | dev_rsp.err, rdata: '0};
                        s_d.ready = 1'b1;
                        s_d.st = ST_IDLE;
                    end else begin
                        // Only now may the controller's mode bits drop
                        s_d.req = make_req(1'b1, cfg_addr(s_q.bank), SZ_WORD,
                            {32'h0, s_q.cfg[s_q.bank] & ~CFG_MODE_BITS});
                        s_d.st = ST_CFG_CLR;
                    end
                end
            end
            ST_CFG_CLR: begin
                if (acked) begin
                    s_d.req.valid = 1'b0;
                    s_d.cfg[s_q.bank] = s_q.cfg[s_q.bank] & ~CFG_MODE_BITS;
                    s_d.sync[s_q.bank] = 1'b0;
                    s_d.rsp = '{valid: 1'b1, err: s_q.err | dev_rsp.err, rdata: '0};
                    s_d.ready = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            default: begin
                // Corrupted state code: drop the bus request and recover
                s_d = ST_RESET;
                s_d.cfg = s_q.cfg;
                s_d.sync = s_q.sync;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_q <= ST_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register
    // No wait input exists here, so nothing of the memory wait line is touched

    assign cmd_ready = s_q.ready;
    assign user_rsp = s_q.rsp;
    assign bank_sync = s_q.sync;
    assign dev_req = s_q.req;

endmodule

// ==== mbd_mode_host_asserts.sv ====
/* Port checker for mbd_mode_host.
   Assumes the package bank map and a device that acks every request. */
`timescale 1ns/1ps
module mbd_mode_host_asserts import mbd_pkg::*; (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire mbd_cmd_t cmd,
    input wire logic cmd_ready,
    input wire mbd_rsp_t user_rsp,
    input wire logic [BANK_MAX-1:0] bank_sync,
    input wire mbd_dev_req_t dev_req,
    input wire mbd_dev_rsp_t dev_rsp
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    logic take;
    logic in_win;
    logic [31:0] cfg_a;
    logic [31:0] fl_a;
    logic [31:0] cfg_w;
    mbd_op_t op_q;
    logic [1:0] bank_q;
    assign take = cmd_valid && cmd_ready;
    assign in_win = cmd.addr >= BANK_BASE[0] && cmd.addr <= BANK_HIGH[BANK_NUM-1];
    assign cfg_a = REG_BASE + CFG_REG_OFFSET + {28'h0, cmd.bank, 2'h0};
    assign fl_a = BANK_BASE[cmd.bank] | FLASH_RCR_ADDR;
    assign cfg_w = dev_req.addr[2] ? dev_req.wdata[63:32] : dev_req.wdata[31:0];
    // Remember the command in flight so its answer can be judged
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            op_q <= OP_READ;
            bank_q <= 2'h0;
        end else if (take) begin
            op_q <= cmd.op;
            bank_q <= cmd.bank;
        end
    end
    ////////////////////////////////////////
    sync_reset_a: assert property ($fell(reset) |-> bank_sync == 4'h0)
        else $error("bank mode not async after reset");
    cfg_first_a: assert property (take && cmd.op == OP_TO_SYNC |=>
        dev_req.valid && dev_req.we && dev_req.addr == $past(cfg_a) && cfg_w[31:30] == 2'h3)
        else $error("sync switch did not start with config write");
    flash_first_a: assert property (take && cmd.op == OP_TO_ASYNC |=>
        dev_req.valid && dev_req.we && dev_req.addr == $past(fl_a))
        else $error("async switch did not start with flash write");
    sync_set_a: assert property (user_rsp.valid && op_q == OP_TO_SYNC |->
        bank_sync[bank_q]) else $error("bank not sync after switch");
    async_back_a: assert property (user_rsp.valid && op_q == OP_TO_ASYNC |->
        !bank_sync[bank_q]) else $error("bank not async after switch");
    other_banks_a: assert property (!$stable(bank_sync) |->
        (bank_sync ^ $past(bank_sync)) == (4'h1 << bank_q))
        else $error("mode of another bank changed");
    refuse_a: assert property (take && cmd.op inside {OP_READ, OP_WRITE} && !in_win |=>
        user_rsp.valid && user_rsp.err && !dev_req.valid)
        else $error("out of window access not refused");
    hold_req_a: assert property (dev_req.valid && !dev_rsp.ack |=>
        dev_req.valid && $stable(dev_req)) else $error("request moved before ack");
    read_pass_a: assert property (take && cmd.op == OP_READ && in_win |=>
        dev_req.valid && !dev_req.we && dev_req.addr == $past(cmd.addr)
        && dev_req.size == $past(cmd.size)) else $error("read not passed on");
    lane_a: assert property (dev_req.valid && dev_req.size == SZ_BYTE |->
        dev_req.strb == 8'h01 << dev_req.addr[2:0]) else $error("byte lane wrong");
    cover property (user_rsp.valid && op_q == OP_TO_SYNC);
    cover property (user_rsp.valid && op_q == OP_TO_ASYNC);
    cover property (user_rsp.valid && user_rsp.err);
endmodule
bind mbd_mode_host mbd_mode_host_asserts u_chk (.core_clk(core_clk), .reset(reset),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .user_rsp(user_rsp),
    .bank_sync(bank_sync), .dev_req(dev_req), .dev_rsp(dev_rsp));

// ==== mbd_dev_model.sv ====
/* Model of the controller registers and the flash read config word.
   Assumes requests hold until ack; the bench sets lat and err_inj. */
`timescale 1ns/1ps
module mbd_dev_model import mbd_pkg::*; (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [3:0] lat,
    input wire logic err_inj,
    input wire mbd_dev_req_t req,
    output mbd_dev_rsp_t rsp
);
    logic [3:0][31:0] cfg_q;
    logic [15:0] lo_q;
    logic [15:0] hi_q;
    logic copy_q;
    logic [3:0] wait_q;
    logic [31:0] wd;
    logic [1:0] b;
    // Word writes sit on their aligned lanes, whatever the low address bits
    assign wd = 32'(req.wdata >> {req.addr[2], 5'h0});
    // Any bank may hold flash or SRAM; all share one rising-edge timing
    assign b = req.addr[25:24];
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cfg_q <= {4{CFG_RESET}};
            rsp <= '0;
            wait_q <= 4'h0;
            lo_q <= 16'h0;
            hi_q <= 16'h0;
            copy_q <= 1'b0;
        end else begin
            rsp.ack <= 1'b0;
            // Released bus toggles so stale data never looks valid
            rsp.rdata <= ~rsp.rdata;
            if (req.valid && !rsp.ack && wait_q < lat) begin
                wait_q <= wait_q + 4'h1;
            end else if (req.valid && !rsp.ack) begin
                wait_q <= 4'h0;
                rsp.ack <= 1'b1;
                rsp.err <= err_inj;
                rsp.rdata <= {req.addr, ~req.addr};
                if (req.we && req.addr[31:28] == 4'h4) begin
                    cfg_q[req.addr[3:2]] <= wd;
                end else if (req.we && req.addr[15:0] == 16'h284f) begin
                    lo_q <= wd[15:0];
                    hi_q <= wd[31:16];
                    copy_q <= cfg_q[b][31];
                end
            end
        end
    end
endmodule

// ==== mbd_mode_host_tb.sv ====
/* Self-checking bench for mbd_mode_host with the device model.
   Assumes the package bank map; commands run one at a time. */
`timescale 1ns/1ps
module mbd_mode_host_tb import mbd_pkg::*;;
    logic core_clk = 1'b0;
    logic reset;
    logic cmd_valid;
    mbd_cmd_t cmd;
    logic cmd_ready;
    mbd_rsp_t user_rsp;
    logic [BANK_MAX-1:0] bank_sync;
    mbd_dev_req_t dev_req;
    mbd_dev_rsp_t dev_rsp;
    logic [3:0] lat;
    logic err_inj;
    mbd_rsp_t got;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #5 core_clk = ~core_clk;
    mbd_mode_host dut (.core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .user_rsp(user_rsp), .bank_sync(bank_sync),
        .dev_req(dev_req), .dev_rsp(dev_rsp));
    mbd_dev_model dev (.core_clk(core_clk), .reset(reset), .lat(lat),
        .err_inj(err_inj), .req(dev_req), .rsp(dev_rsp));
    ////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk_val(input string what, input logic [63:0] exp, input logic [63:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chk_flag(input string what, input logic exp, input logic seen);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask
    // Entered just after an edge; returns just after the answer's edge
    task automatic run(input mbd_op_t op, input logic [1:0] b, input logic [31:0] a,
                       input mbd_size_t sz, input logic [63:0] wd);
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd = '{op, b, a, sz, wd};
        @(posedge core_clk);
        #1 cmd_valid = 1'b0;
        while (user_rsp.valid !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk_flag("rsp_valid", 1'b1, user_rsp.valid);
        got = user_rsp;
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        chk_flag("cmd_ready", 1'b1, cmd_ready);
        chk_val("bank_sync", 64'h0, 64'(bank_sync));
        for (int i = 0; i < 4; i++) chk_val("cfg", 64'(CFG_RESET), 64'(dev.cfg_q[i]));
    endtask
    // Every size in every bank, odd offsets and growing device delay
    task automatic t_reads();
        logic [31:0] a;
        logic [63:0] e;
        for (int s = 0; s < 4; s++) begin
            for (int b = 0; b < 4; b++) begin
                a = BANK_BASE[b] + 32'(b * 5 + s);
                lat = 4'(b);
                run(OP_READ, 2'h0, a, mbd_size_t'(2'(s)), 64'h0);
                e = {a, ~a} >> {a[2:0], 3'h0};
                e = e & ((s == 3) ? 64'hffff_ffff_ffff_ffff : (64'h1 << (8 << s)) - 64'h1);
                chk_val("rdata", e, got.rdata);
                chk_flag("rd_err", 1'b0, got.err);
            end
        end
    endtask
    task automatic t_refuse();
        run(OP_READ, 2'h0, BANK_BASE[0] - 32'h1, SZ_BYTE, 64'h0);
        chk_flag("below_err", 1'b1, got.err);
        run(OP_WRITE, 2'h0, BANK_HIGH[3] + 32'h1, SZ_WORD, 64'h5);
        chk_flag("above_err", 1'b1, got.err);
        run(OP_READ, 2'h0, BANK_HIGH[3], SZ_BYTE, 64'h0);
        chk_flag("edge_err", 1'b0, got.err);
        chk_val("edge_data", 64'h63, got.rdata);
        run(OP_WRITE, 2'h0, BANK_BASE[1], SZ_DWORD, 64'h0123_4567_89ab_cdef);
        chk_flag("dw_err", 1'b0, got.err);
        err_inj = 1'b1;
        run(OP_READ, 2'h0, BANK_BASE[2], SZ_WORD, 64'h0);
        chk_flag("dev_err", 1'b1, got.err);
        err_inj = 1'b0;
    endtask
    task automatic t_modes();
        lat = 4'h2;
        run(OP_TO_SYNC, 2'h2, 32'h0, SZ_WORD, 64'h0);
        chk_val("bank_sync", 64'h4, 64'(bank_sync));
        chk_val("cfg2_mode", 64'h3, 64'(dev.cfg_q[2][31:30]));
        chk_val("cfg1", 64'(CFG_RESET), 64'(dev.cfg_q[1]));
        chk_val("flash_lo", 64'h60, 64'(dev.lo_q));
        chk_val("flash_hi", 64'h3, 64'(dev.hi_q));
        chk_flag("copy_on", 1'b1, dev.copy_q);
        run(OP_TO_SYNC, 2'h0, 32'h0, SZ_WORD, 64'h0);
        chk_val("bank_sync", 64'h5, 64'(bank_sync));
        run(OP_TO_ASYNC, 2'h2, 32'h0, SZ_WORD, 64'h0);
        chk_val("bank_sync", 64'h1, 64'(bank_sync));
        chk_flag("flash_first", 1'b1, dev.copy_q);
        chk_val("cfg2", 64'(CFG_RESET), 64'(dev.cfg_q[2]));
        run(OP_TO_ASYNC, 2'h0, 32'h0, SZ_WORD, 64'h0);
        chk_val("bank_sync", 64'h0, 64'(bank_sync));
        run(OP_READ, 2'h0, BANK_BASE[2] + 32'h8, SZ_WORD, 64'h0);
        chk_val("rd_after", {32'h0, ~(BANK_BASE[2] + 32'h8)}, got.rdata);
    endtask
    ////////////////////////////////////////
    // Whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            tally_and_finish();
        end
    end
    initial begin
        reset = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        lat = 4'h0;
        err_inj = 1'b0;
        repeat (6) @(posedge core_clk);
        #1 reset = 1'b0;
        t_reset();
        t_reads();
        t_refuse();
        t_modes();
        tally_and_finish();
    end
endmodule
